//--- hdl/icd_decoder.sv
// Purpose: Decode operand fields and set instruction cycle timing
// Assumes: A new word is presented each cycle; skip and PC flags are
//   supplied by the execute stage alongside the word
// Notes: Operand outputs update at the end of each four-phase cycle; phase_out changes every clock, exec_strobe pulses one clock per accepted word
`timescale 1ns/1ps
`default_nettype none
`include "icd_defs.svh"
module icd_decoder #(
    parameter int WORD_W = `ICD_WORD_W,
    parameter int FILE_W = `ICD_FILE_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Instruction in
    input wire logic [WORD_W-1:0] instr,
    input wire logic instr_valid,
    input wire logic test_true,
    input wire logic pc_change,
    input wire logic lit_long,
    // Decoded operands
    output icd_pkg::icd_group_t group,
    output logic [FILE_W-1:0] file_addr,
    output logic dest_file,
    output logic dest_acc,
    output logic [7:0] bit_mask,
    output logic [`ICD_LIT11_W-1:0] literal,
    // Timing
    output logic exec_strobe,
    output logic nop_cycle,
    output logic [3:0] phase_out,
    output logic busy
);
    // Parameters the logic cannot serve, refused at elaboration
    if (WORD_W != `ICD_WORD_W || FILE_W != `ICD_FILE_W) begin : g_bad_param
        $error("icd_decoder: word must be 14 bits, file 7 bits");
    end

    icd_pkg::icd_phase_t phase;
    logic cycle_end;
    logic in_nop;
    logic [2:0] bit_sel;
    logic [7:0] dec_mask;
    logic [1:0] grp_bits;
    icd_pkg::icd_group_t dec_group;
    logic [`ICD_LIT11_W-1:0] dec_lit;
    logic take_two;
    logic accept;

    icd_phase_gen u_phase (
        .clk(clk),
        .rst(rst),
        .phase(phase),
        .cycle_end(cycle_end)
    );

    // Group from the top two opcode bits
    assign grp_bits = instr[`ICD_GRP_HI:`ICD_GRP_LO];
    assign dec_group = (grp_bits == `ICD_GRP_BYTE) ?
        icd_pkg::ICD_GRP_BYTE_OP :
        (grp_bits == `ICD_GRP_BIT) ? icd_pkg::ICD_GRP_BIT_OP :
        icd_pkg::ICD_GRP_LITCTL;

    // Bit select lands above the 7-bit file field
    assign bit_sel = instr[`ICD_BIT_LO+2:`ICD_BIT_LO];

    // One mask bit per position of the 8-bit register
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_mask
            assign dec_mask[gi] = (bit_sel == 3'(gi));
        end
    endgenerate

    // Short literal zero-extended; don't-care bits never reach it
    assign dec_lit = lit_long ? instr[`ICD_LIT11_W-1:0] :
        {3'h0, instr[`ICD_LIT8_W-1:0]};

    // Taken test or PC change buys a second, idle cycle
    assign take_two = test_true | pc_change;
    assign accept = cycle_end & instr_valid & ~in_nop;

    // NOP tracking for the second cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            in_nop <= 1'b0;
        end else if (cycle_end) begin
            in_nop <= accept & take_two;
        end
    end

    // Registered operands, captured once per cycle; other groups
    // leave unused fields cleared; an empty slot clears group and dest only, keeping file, mask and literal
    always_ff @(posedge clk) begin
        if (rst) begin
            group <= icd_pkg::ICD_GRP_NONE;
            file_addr <= 7'h00;
            dest_file <= 1'b0;
            dest_acc <= 1'b0;
            bit_mask <= 8'h00;
            literal <= 11'h000;
        end else if (accept) begin
            group <= dec_group;
            file_addr <= (dec_group == icd_pkg::ICD_GRP_LITCTL) ? 7'h00 :
                instr[FILE_W-1:0];
            dest_file <= (dec_group == icd_pkg::ICD_GRP_BYTE_OP) &
                instr[`ICD_DEST_POS];
            dest_acc <= (dec_group == icd_pkg::ICD_GRP_BYTE_OP) &
                ~instr[`ICD_DEST_POS];
            bit_mask <= (dec_group == icd_pkg::ICD_GRP_BIT_OP) ?
                dec_mask : 8'h00;
            literal <= (dec_group == icd_pkg::ICD_GRP_LITCTL) ?
                dec_lit : 11'h000;
        end else if (cycle_end) begin
            group <= icd_pkg::ICD_GRP_NONE;
            dest_file <= 1'b0;
            dest_acc <= 1'b0;
        end
    end

    // Timing outputs, all from flops
    always_ff @(posedge clk) begin
        if (rst) begin
            exec_strobe <= 1'b0;
            nop_cycle <= 1'b0;
            busy <= 1'b0;
            phase_out <= 4'h1;
        end else begin
            exec_strobe <= accept;
            nop_cycle <= cycle_end ? (accept & take_two) : nop_cycle;
            busy <= cycle_end ? (accept & take_two) : busy;
            phase_out <= (cycle_end) ? 4'h1 : {phase_out[2:0], 1'b0};
        end
    end

    a_nop_after_skip: assert property (@(posedge clk) disable iff (rst)
        accept && take_two |=> nop_cycle [*4])
        else $error("taken skip did not give a NOP cycle");

    a_single_cycle: assert property (@(posedge clk) disable iff (rst)
        accept && !take_two |=> !nop_cycle ##3 !in_nop)
        else $error("plain instruction took more than one cycle");

    a_nop_no_exec: assert property (@(posedge clk) disable iff (rst)
        nop_cycle && cycle_end |-> !accept)
        else $error("instruction accepted during NOP cycle");

    a_dest_select: assert property (@(posedge clk) disable iff (rst)
        accept && dec_group == icd_pkg::ICD_GRP_BYTE_OP |=>
        dest_file == $past(instr[`ICD_DEST_POS]) && dest_acc != dest_file)
        else $error("destination select wrong");

    a_bit_onehot: assert property (@(posedge clk) disable iff (rst)
        accept && dec_group == icd_pkg::ICD_GRP_BIT_OP |=>
        $onehot(bit_mask) && bit_mask[$past(bit_sel)])
        else $error("bit mask does not match bit select");

    a_lit_short: assert property (@(posedge clk) disable iff (rst)
        accept && dec_group == icd_pkg::ICD_GRP_LITCTL && !lit_long |=>
        literal[10:8] == 3'h0)
        else $error("short literal carries upper bits");

    a_file_range: assert property (@(posedge clk) disable iff (rst)
        accept && dec_group != icd_pkg::ICD_GRP_LITCTL |=>
        file_addr == $past(instr[6:0]))
        else $error("file address not taken from field");

    a_strobe_spacing: assert property (@(posedge clk) disable iff (rst)
        exec_strobe |=> !exec_strobe [*3])
        else $error("two executes inside one cycle");

    a_group_class: assert property (@(posedge clk) disable iff (rst)
        exec_strobe |-> $onehot(group))
        else $error("instruction left unclassified");

    // Busy is a plain mirror of the NOP flag
    a_busy_mirror: assert property (@(posedge clk) disable iff (rst)
        busy == nop_cycle)
        else $error("busy and nop flag disagree");

    // Visible phase must follow the sequencer, not drift on its own
    a_phase_track: assert property (@(posedge clk) disable iff (rst)
        phase_out == phase)
        else $error("phase output out of step");

    // Long literal takes all eleven low bits
    a_lit_long: assert property (@(posedge clk) disable iff (rst)
        accept && dec_group == icd_pkg::ICD_GRP_LITCTL && lit_long |=>
        literal == $past(instr[10:0]))
        else $error("long literal not taken whole");

    // The idle cycle lasts one cycle only
    a_nop_ends: assert property (@(posedge clk) disable iff (rst)
        nop_cycle && cycle_end |=> !nop_cycle)
        else $error("nop cycle ran past one cycle");

    // An empty slot leaves no stale class behind
    a_idle_clear: assert property (@(posedge clk) disable iff (rst)
        cycle_end && !accept |=> group == icd_pkg::ICD_GRP_NONE &&
        !exec_strobe)
        else $error("empty slot kept a class");

    // Cycle end comes back after exactly four clocks
    a_cycle_four: assert property (@(posedge clk) disable iff (rst)
        cycle_end |=> !cycle_end [*3] ##1 cycle_end)
        else $error("cycle not four clocks long");
endmodule
`default_nettype wire

//--- hdl/icd_defs.svh
// Purpose: Constants for the instruction cycle and operand decoder
// Assumes: 14-bit instruction words, four clock periods per cycle
// Notes: Field positions follow the three instruction formats
//
// Functional notes
// - Each instruction cycle spans four consecutive clock periods, phased internally.
// - Instructions without taken test or PC change finish in one cycle.
// - Taken test or PC change costs two cycles, second one a no-op.
// - Byte ops: d=0 writes accumulator, d=1 writes the file register.
// - Bit ops: bit field picks one bit of the 8-bit file register.
// - Don't-care instruction bits are ignored; tools should fill them with zero.
// - Classify every word as byte, bit, or literal-and-control; extract fields.
// - Instruction words are 14 bits: opcode plus operand fields.
// - File select addresses locations 0x00 through 0x7F.
// - Literal operand is eight or eleven bits depending on instruction.
`ifndef ICD_DEFS_SVH
`define ICD_DEFS_SVH

`define ICD_WORD_W 14
`define ICD_PHASES 4
`define ICD_FILE_W 7
`define ICD_FILE_MAX 7'h7F
`define ICD_BITSEL_W 3
`define ICD_LIT8_W 8
`define ICD_LIT11_W 11
`define ICD_GRP_HI 13
`define ICD_GRP_LO 12
`define ICD_GRP_BYTE 2'h0
`define ICD_GRP_BIT 2'h1
`define ICD_DEST_POS 7
`define ICD_BIT_LO 7
`define ICD_NOP_WORD 14'h0000

`endif

//--- hdl/icd_phase_gen.sv
// Purpose: Four-phase sequencer forming one instruction cycle
// Assumes: Synchronous active-high reset
// Notes: One-hot phase, cycle end flagged in the last phase
`timescale 1ns/1ps
`default_nettype none
module icd_phase_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Phase state
    output icd_pkg::icd_phase_t phase,
    output logic cycle_end
);
    icd_pkg::icd_phase_t next_phase;

    // Rotate through the four phases
    always_comb begin
        case (phase)
            icd_pkg::ICD_Q1: next_phase = icd_pkg::ICD_Q2;
            icd_pkg::ICD_Q2: next_phase = icd_pkg::ICD_Q3;
            icd_pkg::ICD_Q3: next_phase = icd_pkg::ICD_Q4;
            icd_pkg::ICD_Q4: next_phase = icd_pkg::ICD_Q1;
            default: next_phase = icd_pkg::ICD_Q1;
        endcase
    end

    assign cycle_end = (phase == icd_pkg::ICD_Q4);

    // Phase register
    always_ff @(posedge clk) begin
        if (rst) begin
            phase <= icd_pkg::ICD_Q1;
        end else begin
            phase <= next_phase;
        end
    end

    // Every cycle returns to Q1 after exactly four clocks
    a_phase_wrap: assert property (@(posedge clk) disable iff (rst)
        phase == icd_pkg::ICD_Q1 |-> ##4 phase == icd_pkg::ICD_Q1)
        else $error("phase did not wrap in four clocks");
endmodule
`default_nettype wire

//--- hdl/icd_pkg.sv
// Purpose: Types for the instruction cycle and operand decoder
// Assumes: Included constants header
// Notes: Types only
package icd_pkg;
    typedef enum logic [2:0] {
        ICD_GRP_NONE = 3'h0,
        ICD_GRP_BYTE_OP = 3'h1,
        ICD_GRP_BIT_OP = 3'h2,
        ICD_GRP_LITCTL = 3'h4
    } icd_group_t;

    typedef enum logic [3:0] {
        ICD_Q1 = 4'h1,
        ICD_Q2 = 4'h2,
        ICD_Q3 = 4'h4,
        ICD_Q4 = 4'h8
    } icd_phase_t;
endpackage

//--- sim/test_instruction_cycle_and_operand_decode.sv
// Purpose: Self-checking bench for the instruction cycle decoder
// Assumes: Decoder top holds its own four-phase sequencer
// Notes: Table rows first, then empty slot, phase walk and reset cases
`timescale 1ns/1ps
`default_nettype none
module test_instruction_cycle_and_operand_decode;
    // One table row: word and flags, then the decode it should give
    typedef struct packed {
        logic [13:0] w;
        logic tt, pc, ll;
        logic [2:0] g;
        logic [6:0] fa;
        logic df, da;
        logic [7:0] bm;
        logic [10:0] lit;
        logic nop;
    } icd_row_t;

    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [13:0] instr = 14'h0000;
    logic instr_valid = 1'h0;
    logic test_true = 1'h0;
    logic pc_change = 1'h0;
    logic lit_long = 1'h0;
    icd_pkg::icd_group_t group;
    logic [6:0] file_addr;
    logic dest_file, dest_acc, exec_strobe, nop_cycle, busy;
    logic [7:0] bit_mask;
    logic [10:0] literal;
    logic [3:0] phase_out;
    int errors = 0;
    int tests_run = 0;
    int k;
    icd_row_t rows [7];

    // 50 MHz clock
    always #10 clk = ~clk;

    icd_decoder u_dut (.clk(clk), .rst(rst), .instr(instr),
        .instr_valid(instr_valid), .test_true(test_true),
        .pc_change(pc_change), .lit_long(lit_long), .group(group),
        .file_addr(file_addr), .dest_file(dest_file), .dest_acc(dest_acc),
        .bit_mask(bit_mask), .literal(literal), .exec_strobe(exec_strobe),
        .nop_cycle(nop_cycle), .phase_out(phase_out), .busy(busy));

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("Counts: %0d compares, %0d mismatches", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Inputs change only by NBA at a rising edge
    task automatic drive(input logic [13:0] w, input logic v, tt, pc, ll);
        @(posedge clk);
        instr <= w;
        instr_valid <= v;
        test_true <= tt;
        pc_change <= pc;
        lit_long <= ll;
    endtask

    // Clocks until the acceptance strobe; a hang ends the run
    task automatic wait_accept(output int n);
        n = 0;
        for (int i = 1; i <= 20 && n == 0; i++) begin
            @(posedge clk);
            #1;
            if (exec_strobe === 1'h1)
                n = i;
        end
        if (n == 0) begin
            check(24'h000000, 24'h000001);
            test_done();
        end
    endtask

    // Everything idle, phase parked at the first quarter
    task automatic check_reset();
        check({group, file_addr, dest_file, dest_acc, bit_mask}, 24'h000000);
        check({literal, exec_strobe, nop_cycle, busy, phase_out}, 24'h000001);
    endtask

    initial begin
        rows[0] = '{14'h0725, 0, 0, 0, 1, 7'h25, 0, 1, 8'h00, 11'h000, 0};
        rows[1] = '{14'h2FFF, 0, 1, 1, 4, 7'h00, 0, 0, 8'h00, 11'h7FF, 1};
        rows[2] = '{14'h00FF, 0, 0, 0, 1, 7'h7F, 1, 0, 8'h00, 11'h000, 0};
        rows[3] = '{14'h0B85, 1, 0, 0, 1, 7'h05, 1, 0, 8'h00, 11'h000, 1};
        rows[4] = '{14'h1380, 0, 0, 0, 2, 7'h00, 0, 0, 8'h80, 11'h000, 0};
        rows[5] = '{14'h3FAB, 0, 0, 0, 4, 7'h00, 0, 0, 8'h00, 11'h0AB, 0};
        rows[6] = '{14'h107F, 0, 0, 0, 2, 7'h7F, 0, 0, 8'h01, 11'h000, 0};
        repeat (10) @(posedge clk);
        #1;
        check_reset();
        @(posedge clk);
        rst <= 1'h0;
        // Table rows back to back; gap follows the previous row's nop
        for (int i = 0; i < 7; i++) begin
            drive(rows[i].w, 1, rows[i].tt, rows[i].pc, rows[i].ll);
            wait_accept(k);
            if (i > 0)
                check(k + 1, rows[i - 1].nop ? 8 : 4);
            check(group, rows[i].g);
            check(file_addr, rows[i].fa);
            check({dest_file, dest_acc}, {rows[i].df, rows[i].da});
            check(bit_mask, rows[i].bm);
            check(literal, rows[i].lit);
            check({nop_cycle, busy}, {2{rows[i].nop}});
            $display("row %0d test done", i);
        end
        // Empty slot: nothing accepted, group cleared
        drive(14'h0725, 0, 0, 0, 0);
        for (int i = 0; i < 8 && phase_out !== 4'h8; i++)
            @(posedge clk) #1;
        check(phase_out, 4'h8);
        @(posedge clk);
        #1;
        check({group, exec_strobe}, 4'h0);
        // Four one-hot phases on consecutive clocks
        for (int j = 0; j < 4; j++) begin
            check(phase_out, 4'h1 << j);
            check(exec_strobe, 1'h0);
            @(posedge clk);
            #1;
        end
        $display("empty slot and phase test done");
        // Reset in mid-run, then a word must still get through
        drive(14'h1200, 1, 0, 0, 0);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        #1;
        check_reset();
        @(posedge clk);
        rst <= 1'h0;
        wait_accept(k);
        check({group, bit_mask}, {3'h2, 8'h10});
        $display("reset test done");
        test_done();
    end
endmodule
`default_nettype wire
